// ==== rtl/trip_pkg.sv ====
// Purpose: constants for the PWM trip response block
// Assumes: 32-bit AHB-Lite register bus, word-aligned registers
// Notes: register offsets are local choices
// Operation
// - trip sets output B by bits 3-2: 00 hi-z, 01 high, 10 low, 11 none.
// - trip sets output A by bits 1-0: 00 hi-z, 01 high, 10 low, 11 none.
// - only trip inputs enabled in source select act on the outputs.
// - interrupt enable bit 2 lets one-shot trips raise the trip interrupt.
// - interrupt enable bit 1 lets cycle trips raise the trip interrupt.
// - status bit 2 latches any enabled one-shot trip; reads 0 otherwise.
// - one-shot flag stays set until software clears it via clear register.
// - status bit 1 latches any enabled cycle-by-cycle trip event.
// - cycle flag sets again at once if cycle trip input still active.
// - cycle condition releases at counter zero once the input is gone.
// - int flag blocks pulses; clearing it with a trip set pulses again.
`default_nettype none
package trip_pkg;
  localparam logic [7:0] ADDR_ACTION = 8'h00;
  localparam logic [7:0] ADDR_INT_EN = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_CLEAR = 8'h0C;
  localparam logic [7:0] ADDR_SELECT = 8'h10;
  localparam int ACT_B_LSB = 2;
  localparam int ACT_A_LSB = 0;
  localparam int BIT_ONE_SHOT = 2;
  localparam int BIT_CYCLE = 1;
  localparam int BIT_INT = 0;
  localparam int SEL_SHOT_LSB = 8;
  localparam int SEL_CYCLE_LSB = 0;
  localparam int NUM_TRIP = 6;
  localparam logic [3:0] ACTION_RESET = 4'hF;
  localparam logic [2:0] INT_EN_RESET = 3'h0;
  localparam logic [15:0] SELECT_RESET = 16'h0000;
  localparam logic [1:0] ACT_HIZ = 2'h0;
  localparam logic [1:0] ACT_HIGH = 2'h1;
  localparam logic [1:0] ACT_LOW = 2'h2;
endpackage
`default_nettype wire

// ==== rtl/trip_out_stage.sv ====
// Purpose: apply one trip action to one PWM output
// Assumes: inputs from same clock
// Notes: output is registered
`timescale 1ns/1ps
`default_nettype none
module trip_out_stage (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tripped,
  input wire logic [1:0] action,
  input wire logic pwm_in,
  output logic pin_o,
  output logic pin_oe
);
  logic o_d, oe_d, o_q, oe_q;
  always_comb begin
    o_d = pwm_in;
    oe_d = 1'b1;
    if (tripped) begin
      case (action)
        trip_pkg::ACT_HIZ: begin
          o_d = 1'b0;
          oe_d = 1'b0;
        end
        trip_pkg::ACT_HIGH: o_d = 1'b1;
        trip_pkg::ACT_LOW: o_d = 1'b0;
        default: o_d = pwm_in;
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      o_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      o_q <= o_d;
      oe_q <= oe_d;
    end
  end
  assign pin_o = o_q;
  assign pin_oe = oe_q;
endmodule // trip_out_stage
`default_nettype wire

// ==== rtl/pwm_trip_zone_response.sv ====
// Purpose: trip-zone response with AHB-Lite registers
// Assumes: trip pins active low, asynchronous to hclk
// Notes: zero-wait-state slave, always OKAY
//
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module pwm_trip_zone_response (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [5:0] trip_n,
  input wire logic timebase_zero,
  input wire logic pwm_a_in,
  input wire logic pwm_b_in,
  output logic pwm_out_a,
  output logic pwm_out_a_oe,
  output logic pwm_out_b,
  output logic pwm_out_b_oe,
  output logic trip_interrupt
);
  // =========================================
  // trip input synchronisers
  // =========================================
  logic [5:0] s1_q, s2_q, s3_q, trip_q, trip_d;
  always_comb begin
    trip_d = trip_q;
    for (int i = 0; i < trip_pkg::NUM_TRIP; i++) begin
      if (s2_q[i] == s3_q[i]) trip_d[i] = ~s3_q[i];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 6'h3F;
      s2_q <= 6'h3F;
      s3_q <= 6'h3F;
      trip_q <= 6'h00;
    end else begin
      s1_q <= trip_n;
      s2_q <= s1_q;
      s3_q <= s2_q;
      trip_q <= trip_d;
    end
  end

  // =========================================
  // bus slave
  // =========================================
  logic wr_d, wr_q;
  logic [7:0] addr_d, addr_q;
  logic [31:0] rdata_d, rdata_q;
  logic [3:0] action_d, action_q;
  logic [2:0] int_en_d, int_en_q;
  logic [15:0] select_d, select_q;
  logic [2:0] flags_q, flags_d;
  logic ack;

  // any synchronised trip that a source mask enables
  function automatic logic any_enabled(input logic [5:0] trips,
                                       input logic [5:0] mask);
    return |(trips & mask);
  endfunction

  // read view of the registers; unmapped and clear offsets read zero
  function automatic logic [31:0] read_word(input logic [7:0] addr,
                                            input logic [3:0] action,
                                            input logic [2:0] int_en,
                                            input logic [2:0] flags,
                                            input logic [15:0] select);
    logic [31:0] word;
    word = 32'h0000_0000;
    case (addr)
      trip_pkg::ADDR_ACTION: word = {28'h0, action};
      trip_pkg::ADDR_INT_EN: word = {29'h0, int_en};
      trip_pkg::ADDR_FLAGS: word = {29'h0, flags};
      trip_pkg::ADDR_SELECT: word = {16'h0, select};
      default: word = 32'h0000_0000;
    endcase
    return word;
  endfunction

  assign ack = hsel && hready && htrans[1];
  always_comb begin
    wr_d = ack && hwrite;
    addr_d = ack ? haddr[7:0] : 8'hFF;
    action_d = action_q;
    int_en_d = int_en_q;
    select_d = select_q;
    if (wr_q) begin
      case (addr_q)
        trip_pkg::ADDR_ACTION: action_d = hwdata[3:0];
        trip_pkg::ADDR_INT_EN: int_en_d = {hwdata[2:1], 1'b0};
        trip_pkg::ADDR_SELECT: select_d = hwdata[15:0];
        default: ;
      endcase
    end
    // a read right behind a write sees the value that write stores
    rdata_d = 32'h0000_0000;
    if (ack && !hwrite) begin
      rdata_d = read_word(haddr[7:0], action_d, int_en_d, flags_d,
                          select_d);
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      addr_q <= 8'hFF;
      rdata_q <= 32'h0000_0000;
      action_q <= trip_pkg::ACTION_RESET;
      int_en_q <= trip_pkg::INT_EN_RESET;
      select_q <= trip_pkg::SELECT_RESET;
    end else begin
      wr_q <= wr_d;
      addr_q <= addr_d;
      rdata_q <= rdata_d;
      action_q <= action_d;
      int_en_q <= int_en_d;
      select_q <= select_d;
    end
  end
  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // =========================================
  // trip latches, flags and interrupt
  // =========================================
  logic clr_wr;
  logic [2:0] clr;
  logic shot_ev, cyc_ev;
  logic [5:0] shot_mask, cyc_mask;
  logic shot_flag, cyc_lat_d, cyc_lat_q;
  logic irq_d, irq_q;
  assign clr_wr = wr_q && (addr_q == trip_pkg::ADDR_CLEAR);
  assign clr = clr_wr ? hwdata[2:0] : 3'h0;
  assign shot_mask = select_q[trip_pkg::SEL_SHOT_LSB +: 6];
  assign cyc_mask = select_q[trip_pkg::SEL_CYCLE_LSB +: 6];
  // only sources enabled in the select register count as trips
  assign shot_ev = any_enabled(trip_q, shot_mask);
  assign cyc_ev = any_enabled(trip_q, cyc_mask);
  always_comb begin
    flags_d = flags_q;
    irq_d = 1'b0;
    // one-shot latch holds until software clears; set wins over clear
    if (clr[trip_pkg::BIT_ONE_SHOT]) begin
      flags_d[trip_pkg::BIT_ONE_SHOT] = 1'b0;
    end
    if (shot_ev) begin
      flags_d[trip_pkg::BIT_ONE_SHOT] = 1'b1;
    end
    // a cycle trip still present sets its flag again over a clear
    if (clr[trip_pkg::BIT_CYCLE]) begin
      flags_d[trip_pkg::BIT_CYCLE] = 1'b0;
    end
    if (cyc_ev) begin
      flags_d[trip_pkg::BIT_CYCLE] = 1'b1;
    end
    if (clr[trip_pkg::BIT_INT]) begin
      flags_d[trip_pkg::BIT_INT] = 1'b0;
    end
    if (!flags_d[trip_pkg::BIT_INT] &&
        ((flags_d[trip_pkg::BIT_ONE_SHOT] &&
          int_en_q[trip_pkg::BIT_ONE_SHOT]) ||
         (flags_d[trip_pkg::BIT_CYCLE] &&
          int_en_q[trip_pkg::BIT_CYCLE]))) begin
      flags_d[trip_pkg::BIT_INT] = 1'b1;
      irq_d = 1'b1;
    end
  end
  // cycle condition drives outputs, released only at counter zero
  always_comb begin
    cyc_lat_d = cyc_lat_q;
    if (timebase_zero && !cyc_ev) begin
      cyc_lat_d = 1'b0;
    end
    if (cyc_ev) begin
      cyc_lat_d = 1'b1;
    end
  end
  assign shot_flag = flags_q[trip_pkg::BIT_ONE_SHOT];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= 3'h0;
      cyc_lat_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      cyc_lat_q <= cyc_lat_d;
      irq_q <= irq_d;
    end
  end
  assign trip_interrupt = irq_q;

  // =========================================
  // output override
  // =========================================
  logic tripped;
  assign tripped = shot_flag || cyc_lat_q;
  trip_out_stage u_stage_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .tripped(tripped),
    .action(action_q[trip_pkg::ACT_A_LSB +: 2]),
    .pwm_in(pwm_a_in),
    .pin_o(pwm_out_a),
    .pin_oe(pwm_out_a_oe)
  );
  trip_out_stage u_stage_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .tripped(tripped),
    .action(action_q[trip_pkg::ACT_B_LSB +: 2]),
    .pwm_in(pwm_b_in),
    .pin_o(pwm_out_b),
    .pin_oe(pwm_out_b_oe)
  );
endmodule // pwm_trip_zone_response
`default_nettype wire

// ==== bench/trip_partner.sv ====
// Purpose: fault sources and power stage at the far side
// Assumes: trip pins pulled up, an undriven leg is pulled low
// Notes: fault requests are levels, applied just after an edge
`timescale 1ns/1ps
`default_nettype none
module trip_partner (
  input wire logic hclk,
  input wire logic [5:0] fault,
  input wire logic a_o,
  input wire logic a_oe,
  input wire logic b_o,
  input wire logic b_oe,
  output logic [5:0] trip_n,
  output logic [1:0] leg
);
  initial trip_n = 6'h3F;
  always @(posedge hclk) trip_n <= ~fault;
  // a released leg settles at the pull-down level
  assign leg = {b_oe & b_o, a_oe & a_o};
endmodule // trip_partner
`default_nettype wire

// ==== bench/pwm_trip_zone_response_monitor.sv ====
// Purpose: port checks for the trip response block
// Assumes: zero-wait bus, registered outputs
// Notes: bus writes are shadowed to know action and enables
`timescale 1ns/1ps
`default_nettype none
module pwm_trip_zone_response_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic pwm_a_in,
  input wire logic pwm_b_in,
  input wire logic pwm_out_a,
  input wire logic pwm_out_a_oe,
  input wire logic pwm_out_b,
  input wire logic pwm_out_b_oe,
  input wire logic trip_interrupt
);
  logic wr_q, rd_q, int_q;
  logic [7:0] adr_q;
  logic [3:0] act_q;
  logic [2:0] ie_q;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr_q, rd_q, int_q, adr_q, act_q, ie_q} <= {11'h0, 4'hF, 3'h0};
    end else begin
      wr_q <= hsel & hready & htrans[1] & hwrite;
      rd_q <= hsel & hready & htrans[1] & ~hwrite;
      adr_q <= haddr[7:0];
      if (wr_q && adr_q == trip_pkg::ADDR_ACTION) act_q <= hwdata[3:0];
      if (wr_q && adr_q == trip_pkg::ADDR_INT_EN) ie_q <= hwdata[2:0] & 3'h6;
      if (trip_interrupt) int_q <= 1'b1;
      else if (wr_q && adr_q == trip_pkg::ADDR_CLEAR && hwdata[0])
        int_q <= 1'b0;
    end
  end
  property p_a_hiz;
    !pwm_out_a_oe && $past(hresetn) |-> $past(act_q[1:0]) == 2'h0;
  endproperty
  a_a_hiz: assert property (p_a_hiz) else $error("a hiz");
  property p_b_hiz;
    !pwm_out_b_oe && $past(hresetn) |-> $past(act_q[3:2]) == 2'h0;
  endproperty
  a_b_hiz: assert property (p_b_hiz) else $error("b hiz");
  property p_a_force;
    pwm_out_a_oe && pwm_out_a != $past(pwm_a_in) && $past(hresetn)
    |-> $past(act_q[1:0]) == {~pwm_out_a, pwm_out_a};
  endproperty
  a_a_force: assert property (p_a_force) else $error("a force");
  property p_b_force;
    pwm_out_b_oe && pwm_out_b != $past(pwm_b_in) && $past(hresetn)
    |-> $past(act_q[3:2]) == {~pwm_out_b, pwm_out_b};
  endproperty
  a_b_force: assert property (p_b_force) else $error("b force");
  property p_follow; act_q == 4'hF && $past(act_q) == 4'hF && $past(hresetn)
    |-> pwm_out_a == $past(pwm_a_in) && pwm_out_b == $past(pwm_b_in)
    && pwm_out_a_oe && pwm_out_b_oe; endproperty
  a_follow: assert property (p_follow) else $error("follow");
  property p_clr0;
    rd_q && adr_q == trip_pkg::ADDR_CLEAR |-> hrdata == 32'h0;
  endproperty
  a_clr0: assert property (p_clr0) else $error("clear reads");
  property p_int_en; trip_interrupt |-> $past(ie_q) != 3'h0; endproperty
  a_int_en: assert property (p_int_en)
    else $error("int enable");
  property p_one_int; int_q |-> !trip_interrupt; endproperty
  a_one_int: assert property (p_one_int) else $error("int repeat");
endmodule // pwm_trip_zone_response_monitor
bind pwm_trip_zone_response pwm_trip_zone_response_monitor mon_u (.hclk,
  .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .pwm_a_in, .pwm_b_in, .pwm_out_a, .pwm_out_a_oe, .pwm_out_b,
  .pwm_out_b_oe, .trip_interrupt);
`default_nettype wire

// ==== bench/tb_top.sv ====
// Purpose: register-level test of the trip response block
// Assumes: zero-wait slave, trip pins active low
// Notes: one-shot source is trip 0, cycle source is trip 1
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic hclk, hresetn, hsel, hwrite, hready;
  logic timebase_zero, pwm_a_in, pwm_b_in;
  logic hreadyout, hresp, pwm_out_a, pwm_out_a_oe, pwm_out_b, pwm_out_b_oe;
  logic trip_interrupt;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0] htrans, leg;
  logic [2:0] hsize;
  logic [5:0] trip_n, fault;
  logic [3:0] codes [3] = '{4'h0, 4'hF, 4'h6};
  logic [3:0] lvls [3] = '{4'h0, 4'hB, 4'hE};
  int fail_count = 0, samples_checked = 0, cycles = 0, pulses = 0;
  assign hready = hreadyout;
  pwm_trip_zone_response dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .trip_n,
    .timebase_zero, .pwm_a_in, .pwm_b_in, .pwm_out_a, .pwm_out_a_oe,
    .pwm_out_b, .pwm_out_b_oe, .trip_interrupt);
  trip_partner far_u (.hclk, .fault, .a_o(pwm_out_a), .a_oe(pwm_out_a_oe),
    .b_o(pwm_out_b), .b_oe(pwm_out_b_oe), .trip_n, .leg);
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (trip_interrupt === 1'b1) pulses <= pulses + 1;
    if (cycles == 3000) begin
      fail_count = fail_count + 1;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [31:0] e, got);
    samples_checked++;
    if (got !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rdat = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rdat);
    chk("hresp", 32'h0, 32'(hresp));
  endtask
  task automatic pins(input logic [3:0] e);
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk("pins", 32'({pwm_out_b_oe, leg[1], pwm_out_a_oe, leg[0]}), 32'(e));
    @(posedge hclk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, timebase_zero, fault} = '0;
    // a low, b high, reset asserted, word transfers
    {pwm_a_in, pwm_b_in, hresetn, hsize} = {3'h2, 3'h2};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(trip_pkg::ADDR_ACTION, 32'hF);
    rd(trip_pkg::ADDR_INT_EN, 32'h0);
    rd(trip_pkg::ADDR_FLAGS, 32'h0);
    rd(8'h20, 32'h0);
    bus(1'b1, trip_pkg::ADDR_SELECT, 32'h0102);
    bus(1'b1, trip_pkg::ADDR_INT_EN, 32'h6);
    bus(1'b1, trip_pkg::ADDR_ACTION, 32'h9);
    fault <= 6'h04;
    repeat (12) @(posedge hclk);
    rd(trip_pkg::ADDR_FLAGS, 32'h0);
    pins(4'hE);
    fault <= 6'h01;
    repeat (12) @(posedge hclk);
    fault <= 6'h00;
    pins(4'hB);
    {pwm_a_in, pwm_b_in} <= 2'b10;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, trip_pkg::ADDR_ACTION, 32'(codes[i]));
      pins(lvls[i]);
    end
    rd(trip_pkg::ADDR_FLAGS, 32'h5);
    chk("pulses", 32'h1, 32'(pulses));
    bus(1'b1, trip_pkg::ADDR_CLEAR, 32'h0);
    rd(trip_pkg::ADDR_CLEAR, 32'h0);
    rd(trip_pkg::ADDR_FLAGS, 32'h5);
    bus(1'b1, trip_pkg::ADDR_CLEAR, 32'h1);
    rd(trip_pkg::ADDR_FLAGS, 32'h5);
    chk("pulses", 32'h2, 32'(pulses));
    bus(1'b1, trip_pkg::ADDR_CLEAR, 32'h5);
    rd(trip_pkg::ADDR_FLAGS, 32'h0);
    fault <= 6'h02;
    repeat (12) @(posedge hclk);
    bus(1'b1, trip_pkg::ADDR_CLEAR, 32'h3);
    rd(trip_pkg::ADDR_FLAGS, 32'h3);
    chk("pulses", 32'h4, 32'(pulses));
    fault <= 6'h00;
    repeat (8) @(posedge hclk);
    pins(4'hE);
    timebase_zero <= 1'b1;
    @(posedge hclk);
    timebase_zero <= 1'b0;
    pins(4'hB);
    bus(1'b1, trip_pkg::ADDR_INT_EN, 32'h0);
    bus(1'b1, trip_pkg::ADDR_CLEAR, 32'h7);
    fault <= 6'h03;
    repeat (12) @(posedge hclk);
    rd(trip_pkg::ADDR_FLAGS, 32'h6);
    chk("pulses", 32'h4, 32'(pulses));
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
